/* File: hdl/switch_port_intx_msi_aggregator.sv */
// Interrupt, MSI and legacy wire aggregation for a three-port switch
// Notes on behaviour
// (RULE1) Downstream interrupts come from hot-plug and enabled bandwidth status bits.
// (RULE2) Downstream ports use only wire A for their own INTx.
// (RULE3) Unmasked assertion with MSI enabled makes one MSI; negation makes nothing.
// (RULE4) MSI off, INTx allowed: assertion requests Assert_INTA from the core.
// (RULE5) Negation requests Deassert_INTA; with INTx disabled neither edge requests anything.
// (RULE6) Condition ends once each causing status bit is masked or cleared.
// (RULE7) All downstream MSIs go to the upstream port; software sets routable addresses.
// (RULE8) Upstream port signals internal parity and config read errors by INTx or MSI.
// (RULE9) Upstream MSI capability linked only when unlocked pointer write of D0.
// (RULE10) Every port keeps separate aggregated state for wires A to D.
// (RULE11) Upstream status register shows switch-wide aggregate of all four wires.
// (RULE12) Downstream status shows own plus received INTx, before mapping.
// (RULE13) Upstream sends Assert_INTx when its aggregate wire rises.
// (RULE14) Upstream sends Deassert_INTx when its aggregate wire falls.
// (RULE15) Downstream bridges pass received wires through without remapping.
// (RULE16) Upstream wires gather port 2 and port 3 wires by the fixed swizzle.
// (RULE17) A downstream contribution holds received and self-generated wires.
// (RULE18) Link down negates that port's wires and updates the upstream aggregate.
// (RULE19) Upstream wire is OR of mapped contributions and upstream internal interrupt.
module switch_port_intx_msi_aggregator
	import irq_agg_pkg::*;
(
	// Clock and reset
	input  wire logic                           mclk,
	input  wire logic                           rstn,
	// Avalon-MM register slave
	input  wire logic [irq_agg_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                           avs_read,
	input  wire logic                           avs_write,
	input  wire logic [irq_agg_pkg::DATA_W-1:0] avs_writedata,
	input  wire logic [3:0]                     avs_byteenable,
	output logic      [irq_agg_pkg::DATA_W-1:0] avs_readdata,
	output logic                                avs_waitrequest,
	// Downstream port events and link state
	input  wire logic [irq_agg_pkg::NUM_DS-1:0] hp_evt,
	input  wire logic [irq_agg_pkg::NUM_DS-1:0] bw_mgmt_status_bit,
	input  wire logic [irq_agg_pkg::NUM_DS-1:0] autonomous_bw_status_bit,
	input  wire logic [irq_agg_pkg::NUM_DS-1:0] dl_up,
	// INTx messages received from downstream link partners
	input  wire logic [irq_agg_pkg::NUM_DS-1:0] rx_assert,
	input  wire logic [irq_agg_pkg::NUM_DS-1:0] rx_deassert,
	input  wire logic [1:0]                     rx_wire_ds0,
	input  wire logic [1:0]                     rx_wire_ds1,
	// Upstream internal error events
	input  wire logic                           err_parity_evt,
	input  wire logic                           err_cfg_evt,
	// Requests to the switch core
	output logic      [irq_agg_pkg::NUM_DS-1:0] ds_assert_req,
	output logic      [irq_agg_pkg::NUM_DS-1:0] ds_deassert_req,
	output logic                                msi_req,
	output logic      [1:0]                     msi_port,
	output logic      [63:0]                    msi_addr,
	// Legacy messages to the root
	output logic                                up_assert_msg,
	output logic                                up_deassert_msg,
	output logic      [1:0]                     up_msg_wire
);
	import irq_agg_pkg::*;

	typedef struct packed {
		logic                    wreq;
		logic [DATA_W-1:0]       rdata;
		logic [3:0]              up_ctrl;
		logic [1:0]              up_err;
		logic                    unlock;
		logic [7:0]              next_ptr;
		logic                    up_cond_prev;
		logic                    up_inta;
		logic [NUM_DS-1:0][4:0]  ds_ctrl;
		logic [NUM_DS-1:0][2:0]  ds_sts;
		logic [NUM_DS-1:0][3:0]  ds_rx;
		logic [NUM_DS-1:0]       own_inta;
		logic [NUM_DS-1:0]       cond_prev;
		logic [NUM_DS-1:0][31:0] msi_lo;
		logic [NUM_DS-1:0][31:0] msi_hi;
		logic [NUM_DS:0]         msi_pend;
		logic [3:0]              sent;
		logic [NUM_DS-1:0]       areq;
		logic [NUM_DS-1:0]       dreq;
		logic                    msi_req;
		logic [1:0]              msi_port;
		logic [63:0]             msi_addr;
		logic                    amsg;
		logic                    dmsg;
		logic [1:0]              msg_wire;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return r;
	endfunction : be_merge

	function automatic logic [7:0] ds_base(input int p);
		return 8'(DS_BASE + DS_STRIDE * p);
	endfunction : ds_base

	// Fixed swizzle, downstream bridges themselves never remap
	function automatic logic [3:0] up_map(input logic [3:0] p2, input logic [3:0] p3);
		logic [3:0] r;
		r[WIRE_A] = p2[WIRE_C] | p3[WIRE_B]; // RULE16
		r[WIRE_B] = p2[WIRE_D] | p3[WIRE_C]; // RULE16
		r[WIRE_C] = p2[WIRE_A] | p3[WIRE_D]; // RULE16
		r[WIRE_D] = p2[WIRE_B] | p3[WIRE_A]; // RULE16
		return r;
	endfunction : up_map

	logic [NUM_DS-1:0]       ds_cond;
	logic [NUM_DS-1:0][3:0]  ds_agg;
	logic [3:0]              up_agg;
	logic                    up_cond;
	logic                    msi_linked;
	logic [NUM_DS-1:0][1:0]  rx_wire;

	assign rx_wire[0] = rx_wire_ds0;
	assign rx_wire[1] = rx_wire_ds1;

	always_comb
	begin
		for (int p = 0; p < NUM_DS; p++)
		begin
			// Status bits count only while their enable is set
			ds_cond[p] = (s_q.ds_sts[p][STS_HP] & s_q.ds_ctrl[p][DS_HP_EN])
				| (s_q.ds_sts[p][STS_BWM] & s_q.ds_ctrl[p][DS_BWM_EN])
				| (s_q.ds_sts[p][STS_ABW] & s_q.ds_ctrl[p][DS_ABW_EN]); // RULE1 RULE6
			// Own interrupt only ever on wire A
			ds_agg[p] = dl_up[p] ? (s_q.ds_rx[p] | {3'h0, s_q.own_inta[p]}) : 4'h0; // RULE2 RULE17 RULE18
		end
	end

	assign up_cond    = (s_q.up_err[ERR_PAR] & s_q.up_ctrl[UP_PAR_EN])
		| (s_q.up_err[ERR_CFG] & s_q.up_ctrl[UP_CFG_EN]); // RULE8
	assign msi_linked = (s_q.next_ptr == MSI_CAP_PTR); // RULE9
	assign up_agg     = up_map(ds_agg[0], ds_agg[1]) | {3'h0, s_q.up_inta}; // RULE19 RULE10

	always_comb
	begin
		logic        acc;
		logic        wr;
		logic [31:0] rd;
		logic [31:0] wv;
		logic [7:0]  ofs;
		logic [3:0]  diff;
		logic        own;
		logic        legacy;
		acc    = 1'b0;
		wr     = 1'b0;
		rd     = 32'h0000_0000;
		wv     = 32'h0000_0000;
		ofs    = 8'h00;
		diff   = 4'h0;
		own    = 1'b0;
		legacy = 1'b0;
		s_d    = s_q;
		s_d.areq    = '0;
		s_d.dreq    = '0;
		s_d.msi_req = 1'b0;
		s_d.amsg    = 1'b0;
		s_d.dmsg    = 1'b0;

		// One wait state, then the access is taken while waitrequest is low
		acc = (avs_read | avs_write) & ~s_q.wreq;
		wr  = avs_write & acc;
		if ((avs_read | avs_write) & s_q.wreq)
			s_d.wreq = 1'b0;
		else
			s_d.wreq = 1'b1;

		// Read mux and write decode
		if (avs_address == UP_CTRL_OFS)
		begin
			rd = {28'h0, s_q.up_ctrl};
			wv = be_merge(rd, avs_writedata, avs_byteenable);
			if (wr)
				s_d.up_ctrl = wv[3:0];
		end
		else if (avs_address == UP_ERR_OFS)
		begin
			rd = {30'h0, s_q.up_err};
			wv = be_merge(32'h0, avs_writedata, avs_byteenable);
			if (wr)
				s_d.up_err = s_q.up_err & ~wv[1:0];
		end
		else if (avs_address == UP_IRQ_OFS)
			rd = {28'h0, up_agg}; // RULE11
		else if (avs_address == UNLOCK_OFS)
		begin
			rd = {31'h0, s_q.unlock};
			wv = be_merge(rd, avs_writedata, avs_byteenable);
			if (wr)
				s_d.unlock = wv[0];
		end
		else if (avs_address == PM_CAP_OFS)
		begin
			rd = {23'h0, msi_linked, s_q.next_ptr};
			wv = be_merge(rd, avs_writedata, avs_byteenable);
			// Pointer is write-locked unless the unlock bit is set
			if (wr && s_q.unlock)
				s_d.next_ptr = wv[7:0]; // RULE9
		end
		else
		begin
			for (int p = 0; p < NUM_DS; p++)
			begin
				if ((avs_address & ~DS_OFS_MASK) == ds_base(p))
				begin
					ofs = avs_address & DS_OFS_MASK;
					if (ofs == DS_CTRL_OFS)
					begin
						rd = {27'h0, s_q.ds_ctrl[p]};
						wv = be_merge(rd, avs_writedata, avs_byteenable);
						if (wr)
							s_d.ds_ctrl[p] = wv[4:0];
					end
					else if (ofs == DS_STS_OFS)
					begin
						rd = {29'h0, s_q.ds_sts[p]};
						wv = be_merge(32'h0, avs_writedata, avs_byteenable);
						if (wr)
							s_d.ds_sts[p] = s_q.ds_sts[p] & ~wv[2:0]; // RULE6
					end
					else if (ofs == DS_IRQ_OFS)
						rd = {28'h0, ds_agg[p]}; // RULE12
					else if (ofs == DS_MSILO_OFS)
					begin
						rd = s_q.msi_lo[p];
						if (wr)
							s_d.msi_lo[p] = be_merge(rd, avs_writedata, avs_byteenable);
					end
					else if (ofs == DS_MSIHI_OFS)
					begin
						rd = s_q.msi_hi[p];
						if (wr)
							s_d.msi_hi[p] = be_merge(rd, avs_writedata, avs_byteenable);
					end
				end
			end
		end
		if ((avs_read | avs_write) & s_q.wreq)
			s_d.rdata = rd;

		// Hardware sets after the software clear so a coincident event survives
		s_d.up_err[ERR_PAR] = s_d.up_err[ERR_PAR] | err_parity_evt;
		s_d.up_err[ERR_CFG] = s_d.up_err[ERR_CFG] | err_cfg_evt;

		// MSI scheduler: one per cycle, lowest source first
		if (s_q.msi_pend[0])
		begin
			s_d.msi_req      = 1'b1;
			s_d.msi_port     = PORT_UP;
			s_d.msi_addr     = 64'h0;
			s_d.msi_pend[0]  = 1'b0;
		end
		else if (s_q.msi_pend[1])
		begin
			s_d.msi_req      = 1'b1;
			s_d.msi_port     = PORT_DS0;
			s_d.msi_addr     = {s_q.msi_hi[0], s_q.msi_lo[0]}; // RULE7
			s_d.msi_pend[1]  = 1'b0;
		end
		else if (s_q.msi_pend[2])
		begin
			s_d.msi_req      = 1'b1;
			s_d.msi_port     = PORT_DS1;
			s_d.msi_addr     = {s_q.msi_hi[1], s_q.msi_lo[1]}; // RULE7
			s_d.msi_pend[2]  = 1'b0;
		end

		// Upstream internal error interrupt: MSI only once the capability is linked
		s_d.up_cond_prev = up_cond;
		if (up_cond && !s_q.up_cond_prev && msi_linked && s_q.up_ctrl[CTRL_MSI_EN])
			s_d.msi_pend[0] = 1'b1; // RULE8
		s_d.up_inta = up_cond & ~(msi_linked & s_q.up_ctrl[CTRL_MSI_EN])
			& ~s_q.up_ctrl[CTRL_LEGACY_IRQ_DISABLE]; // RULE8 RULE19

		for (int p = 0; p < NUM_DS; p++)
		begin
			s_d.ds_sts[p][STS_HP]  = s_d.ds_sts[p][STS_HP] | hp_evt[p];
			s_d.ds_sts[p][STS_BWM] = s_d.ds_sts[p][STS_BWM] | bw_mgmt_status_bit[p]; // RULE1
			s_d.ds_sts[p][STS_ABW] = s_d.ds_sts[p][STS_ABW] | autonomous_bw_status_bit[p]; // RULE1
			s_d.cond_prev[p] = ds_cond[p];
			if (ds_cond[p] && !s_q.cond_prev[p] && s_q.ds_ctrl[p][CTRL_MSI_EN])
				s_d.msi_pend[p+1] = 1'b1; // RULE3 RULE7
			legacy = ~s_q.ds_ctrl[p][CTRL_MSI_EN] & ~s_q.ds_ctrl[p][CTRL_LEGACY_IRQ_DISABLE];
			own = ds_cond[p] & legacy;
			s_d.own_inta[p] = own; // RULE2
			s_d.areq[p] = legacy & own & ~s_q.own_inta[p]; // RULE4
			s_d.dreq[p] = legacy & ~own & s_q.own_inta[p]; // RULE5
			// Received messages are kept per wire exactly as seen on the link
			if (!dl_up[p])
				s_d.ds_rx[p] = 4'h0; // RULE18
			else if (rx_assert[p])
				s_d.ds_rx[p][rx_wire[p]] = 1'b1; // RULE15
			else if (rx_deassert[p])
				s_d.ds_rx[p][rx_wire[p]] = 1'b0; // RULE15
		end

		// Root messages follow aggregate edges, one wire per cycle
		diff = up_agg ^ s_q.sent;
		for (int i = 3; i >= 0; i--)
		begin
			if (diff[i])
			begin
				s_d.msg_wire = 2'(i);
				s_d.amsg     = up_agg[i]; // RULE13
				s_d.dmsg     = ~up_agg[i]; // RULE14
			end
		end
		if (s_d.amsg || s_d.dmsg)
			s_d.sent[s_d.msg_wire] = up_agg[s_d.msg_wire];
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q          <= '0;
			s_q.wreq     <= 1'b1;
			s_q.up_ctrl  <= UP_CTRL_RST;
			s_q.next_ptr <= PM_NEXT_RST;
			s_q.ds_ctrl  <= {NUM_DS{DS_CTRL_RST}};
		end
		else
			s_q <= s_d;
	end

	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.wreq;
	assign ds_assert_req   = s_q.areq;
	assign ds_deassert_req = s_q.dreq;
	assign msi_req         = s_q.msi_req;
	assign msi_port        = s_q.msi_port;
	assign msi_addr        = s_q.msi_addr;
	assign up_assert_msg   = s_q.amsg;
	assign up_deassert_msg = s_q.dmsg;
	assign up_msg_wire     = s_q.msg_wire;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_amsg_a_wire;
		up_assert_msg && up_msg_wire == 2'h0;
	endsequence
	sequence s_dmsg_a_wire;
		up_deassert_msg && up_msg_wire == 2'h0;
	endsequence
	sequence s_msi_ds0;
		msi_req && msi_port == PORT_DS0;
	endsequence

	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait state");
	ds_msi_a: assert property ($rose(ds_cond[0]) && s_q.ds_ctrl[0][CTRL_MSI_EN] |-> ##[2:4] s_msi_ds0) // RULE3
		else $error("downstream MSI missing after condition rose");
	msi_no_negate_a: assert property ($fell(ds_cond[0]) && s_q.ds_ctrl[0][CTRL_MSI_EN] && !s_q.msi_pend[1]
		|=> ##1 !(msi_req && msi_port == PORT_DS0)) // RULE3
		else $error("MSI sent on condition negation");
	ds_inta_a: assert property ($rose(ds_cond[0]) && !s_q.ds_ctrl[0][CTRL_MSI_EN]
		&& !s_q.ds_ctrl[0][CTRL_LEGACY_IRQ_DISABLE] |=> ds_assert_req[0]) // RULE4
		else $error("Assert_INTA request missing");
	intx_off_a: assert property (s_q.ds_ctrl[0][CTRL_LEGACY_IRQ_DISABLE] && !s_q.ds_ctrl[0][CTRL_MSI_EN]
		|=> !ds_assert_req[0] && !ds_deassert_req[0]) // RULE5
		else $error("INTA request while INTx disabled");
	root_assert_a: assert property ($rose(up_agg[0]) |-> ##[1:4] s_amsg_a_wire) // RULE13
		else $error("Assert_INTA to root missing");
	root_deassert_a: assert property ($fell(up_agg[0]) |-> ##[1:4] s_dmsg_a_wire) // RULE14
		else $error("Deassert_INTA to root missing");
	link_down_a: assert property (!dl_up[1] |=> s_q.ds_rx[1] == 4'h0) // RULE18
		else $error("wires still set on a downed link");
	wire_map_a: assert property (ds_agg[0][WIRE_A] || ds_agg[1][WIRE_D] |-> up_agg[WIRE_C]) // RULE16
		else $error("upstream wire C does not gather its sources");
	ptr_lock_a: assert property (avs_write && !avs_waitrequest && avs_address == PM_CAP_OFS && !s_q.unlock
		|=> $stable(s_q.next_ptr)) // RULE9
		else $error("capability pointer changed while locked");
endmodule : switch_port_intx_msi_aggregator

/* File: common/irq_agg_pkg.sv */
// Constants shared by the switch port interrupt aggregator
package irq_agg_pkg;
	localparam int          NUM_DS       = 2;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	// Upstream port register byte offsets
	localparam logic [7:0]  UP_CTRL_OFS  = 8'h00;
	localparam logic [7:0]  UP_ERR_OFS   = 8'h04;
	localparam logic [7:0]  UP_IRQ_OFS   = 8'h08;
	localparam logic [7:0]  UNLOCK_OFS   = 8'h0C;
	localparam logic [7:0]  PM_CAP_OFS   = 8'h10;
	// Downstream port pages: base + stride * index, offset within page
	localparam logic [7:0]  DS_BASE      = 8'h20;
	localparam logic [7:0]  DS_STRIDE    = 8'h20;
	localparam logic [7:0]  DS_OFS_MASK  = 8'h1F;
	localparam logic [7:0]  DS_CTRL_OFS  = 8'h00;
	localparam logic [7:0]  DS_STS_OFS   = 8'h04;
	localparam logic [7:0]  DS_IRQ_OFS   = 8'h08;
	localparam logic [7:0]  DS_MSILO_OFS = 8'h0C;
	localparam logic [7:0]  DS_MSIHI_OFS = 8'h10;
	// Control fields (both ports), enables
	localparam int          CTRL_MSI_EN  = 0;
	localparam int          CTRL_LEGACY_IRQ_DISABLE   = 1;
	localparam int          DS_HP_EN     = 2;
	localparam int          DS_BWM_EN    = 3;
	localparam int          DS_ABW_EN    = 4;
	localparam int          UP_PAR_EN    = 2;
	localparam int          UP_CFG_EN    = 3;
	// Status fields
	localparam int          STS_HP       = 0;
	localparam int          STS_BWM      = 1;
	localparam int          STS_ABW      = 2;
	localparam int          ERR_PAR      = 0;
	localparam int          ERR_CFG      = 1;
	// Legacy wires and port numbers
	localparam int          WIRE_A       = 0;
	localparam int          WIRE_B       = 1;
	localparam int          WIRE_C       = 2;
	localparam int          WIRE_D       = 3;
	localparam logic [1:0]  PORT_UP      = 2'h0;
	localparam logic [1:0]  PORT_DS0     = 2'h2;
	localparam logic [1:0]  PORT_DS1     = 2'h3;
	// Reset values and the pointer that links the upstream MSI capability
	localparam logic [7:0]  PM_NEXT_RST  = 8'h00;
	localparam logic [7:0]  MSI_CAP_PTR  = 8'hD0;
	localparam logic [4:0]  DS_CTRL_RST  = 5'h00;
	localparam logic [3:0]  UP_CTRL_RST  = 4'h0;
endpackage : irq_agg_pkg

/* File: verif/root_model.sv */
// Root complex model that tracks the legacy wires seen from the upstream port
module root_model
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Legacy messages from the upstream port
	input  wire logic       up_assert_msg,
	input  wire logic       up_deassert_msg,
	input  wire logic [1:0] up_msg_wire,
	// Observed wire state and protocol slips
	output logic      [3:0] root_wires,
	output logic      [7:0] proto_errs
);
	timeunit 1ns;
	timeprecision 1ps;

	// A repeated Assert or Deassert on one wire means a missed edge
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			root_wires <= 4'h0;
			proto_errs <= 8'h00;
		end
		else if (up_assert_msg || up_deassert_msg)
		begin
			if (root_wires[up_msg_wire] == up_assert_msg)
				proto_errs <= proto_errs + 8'h01;
			root_wires[up_msg_wire] <= up_assert_msg;
		end
	end
endmodule : root_model

/* File: verif/switch_port_intx_msi_aggregator_test.sv */
// Self-checking bench for the switch port interrupt aggregator
module switch_port_intx_msi_aggregator_test import irq_agg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] P3 = DS_BASE + DS_STRIDE;
	logic              mclk, rstn, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, rdq;
	logic [3:0]        avs_byteenable, root_wires, be;
	logic [1:0]        hp_evt, bw_mgmt_status_bit, autonomous_bw_status_bit, dl_up;
	logic [1:0]        rx_assert, rx_deassert, rx_wire_ds0, rx_wire_ds1, u;
	logic              err_parity_evt, err_cfg_evt, msi_req, up_assert_msg, up_deassert_msg;
	logic [1:0]        ds_assert_req, ds_deassert_req, msi_port, up_msg_wire;
	logic [63:0]       msi_addr, exp_addr;
	logic [7:0]        proto_errs, b;
	logic [7:0]        exp_q[$];
	int                miscompares, n_tests, seed, s, p, w;

	switch_port_intx_msi_aggregator dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.hp_evt(hp_evt), .bw_mgmt_status_bit(bw_mgmt_status_bit),
		.autonomous_bw_status_bit(autonomous_bw_status_bit), .dl_up(dl_up), .rx_assert(rx_assert),
		.rx_deassert(rx_deassert), .rx_wire_ds0(rx_wire_ds0), .rx_wire_ds1(rx_wire_ds1),
		.err_parity_evt(err_parity_evt), .err_cfg_evt(err_cfg_evt), .ds_assert_req(ds_assert_req),
		.ds_deassert_req(ds_deassert_req), .msi_req(msi_req), .msi_port(msi_port), .msi_addr(msi_addr),
		.up_assert_msg(up_assert_msg), .up_deassert_msg(up_deassert_msg), .up_msg_wire(up_msg_wire));
	root_model root (.mclk(mclk), .rstn(rstn), .up_assert_msg(up_assert_msg),
		.up_deassert_msg(up_deassert_msg), .up_msg_wire(up_msg_wire), .root_wires(root_wires),
		.proto_errs(proto_errs));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	// Held until the edge that samples waitrequest low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rdq = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check({32'h0, rdq}, {32'h0, e});
	endtask : rd

	task ds_evt(input int src, input int prt);
		@(posedge mclk);
		case (src)
			0: hp_evt[prt] <= 1'b1;
			1: bw_mgmt_status_bit[prt] <= 1'b1;
			default: autonomous_bw_status_bit[prt] <= 1'b1;
		endcase
		@(posedge mclk);
		hp_evt <= 2'b00;
		bw_mgmt_status_bit <= 2'b00;
		autonomous_bw_status_bit <= 2'b00;
	endtask : ds_evt

	task rx(input int prt, input logic [1:0] wire_n, input logic asrt);
		@(posedge mclk);
		if (prt == 1)
			rx_wire_ds1 <= wire_n;
		else
			rx_wire_ds0 <= wire_n;
		if (asrt)
			rx_assert[prt] <= 1'b1;
		else
			rx_deassert[prt] <= 1'b1;
		@(posedge mclk);
		rx_assert <= 2'b00;
		rx_deassert <= 2'b00;
	endtask : rx

	task up_evt(input logic cfg);
		@(posedge mclk);
		err_parity_evt <= !cfg;
		err_cfg_evt <= cfg;
		@(posedge mclk);
		err_parity_evt <= 1'b0;
		err_cfg_evt <= 1'b0;
	endtask : up_evt

	// Long quiet tail so that a stray request still shows up
	task drain;
		for (int k = 0; k < 40 && exp_q.size() != 0; k++)
			@(posedge mclk);
		repeat (8) @(posedge mclk);
		check(64'(exp_q.size()), 64'h0);
	endtask : drain

	task done(input string nm);
		drain();
		$display("test %s finished", nm);
	endtask : done

	// Codes: 1x/2x root assert/deassert, 3x/4x core requests, 5x MSI
	task seen_evt(input logic [7:0] c);
		if (exp_q.size() == 0)
			check({56'h0, c}, 64'hFF);
		else
			check({56'h0, c}, {56'h0, exp_q.pop_front()});
		if (c[7:4] == 4'h5)
			check(msi_addr, exp_addr);
	endtask : seen_evt

	always @(posedge mclk)
	begin
		if (rstn === 1'b1)
		begin
			for (int i = 0; i < NUM_DS; i++)
			begin
				if (ds_assert_req[i] === 1'b1) seen_evt(8'h30 + 8'(i));
				if (ds_deassert_req[i] === 1'b1) seen_evt(8'h40 + 8'(i));
			end
			if (up_assert_msg === 1'b1) seen_evt({6'h04, up_msg_wire});
			if (up_deassert_msg === 1'b1) seen_evt({6'h08, up_msg_wire});
			if (msi_req === 1'b1) seen_evt({6'h14, msi_port});
		end
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		tally_and_finish();
	end

	initial
	begin
		{seed, miscompares, n_tests, rstn} = {32'd89283, 32'd0, 32'd0, 1'b0};
		{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = {8'h00, 2'b00, 32'h0, 4'hF};
		{hp_evt, bw_mgmt_status_bit, autonomous_bw_status_bit, dl_up} = 8'h03;
		{rx_assert, rx_deassert, rx_wire_ds0, rx_wire_ds1, err_parity_evt, err_cfg_evt} = 10'h000;
		exp_addr = 64'h0;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		rd(UP_CTRL_OFS, {28'h0, UP_CTRL_RST});
		rd(UP_IRQ_OFS, 32'h0);
		rd(DS_BASE, {27'h0, DS_CTRL_RST});
		wr(8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, 32'h0);
		rd(PM_CAP_OFS, {24'h0, PM_NEXT_RST});
		done("reset");
		// Middle source runs on port 3 so both ports' core requests are seen
		for (s = 0; s < 3; s++)
		begin
			p = s % 2;
			b = DS_BASE + 8'(p) * DS_STRIDE;
			wr(b, 32'h1 << (DS_HP_EN + s));
			exp_q.push_back(8'h30 + 8'(p));
			exp_q.push_back(8'h12 + 8'(p));
			ds_evt(s, p);
			drain();
			rd(b + DS_IRQ_OFS, 32'h1);
			rd(UP_IRQ_OFS, 32'h4 << p);
			exp_q.push_back(8'h40 + 8'(p));
			exp_q.push_back(8'h22 + 8'(p));
			if (s == 1)
				wr(b, 32'h0);
			else
				wr(b + DS_STS_OFS, 32'h1 << s);
			drain();
			wr(b + DS_STS_OFS, 32'h7);
		end
		done("own_sources");
		wr(DS_BASE, 32'h6);
		ds_evt(0, 0);
		drain();
		wr(DS_BASE + DS_STS_OFS, 32'h1);
		done("intx_disabled");
		for (p = 0; p < 2; p++)
		begin
			b = DS_BASE + 8'(p) * DS_STRIDE;
			exp_addr = {$random(seed), $random(seed)} & 64'hFFFF_FFFF_FFFF_FFFC;
			wr(b + DS_MSILO_OFS, exp_addr[31:0]);
			wr(b + DS_MSIHI_OFS, exp_addr[63:32]);
			// Partial rewrite of the high word through random lanes
			be = 4'($random(seed));
			w = $random(seed);
			avs_byteenable <= be;
			wr(b + DS_MSIHI_OFS, 32'(w));
			avs_byteenable <= 4'hF;
			for (int k = 0; k < 4; k++)
				if (be[k])
					exp_addr[32 + k*8 +: 8] = w[k*8 +: 8];
			wr(b, 32'h5);
			exp_q.push_back(8'h52 + 8'(p));
			ds_evt(0, p);
			drain();
			wr(b + DS_STS_OFS, 32'h1);
		end
		done("msi");
		for (p = 0; p < 2; p++)
			for (w = 0; w < 4; w++)
			begin
				u = 2'(w + 2 + p);
				exp_q.push_back({6'h04, u});
				rx(p, 2'(w), 1'b1);
				drain();
				rd(DS_BASE + 8'(p) * DS_STRIDE + DS_IRQ_OFS, 32'h1 << w);
				rd(UP_IRQ_OFS, 32'h1 << u);
				check({60'h0, root_wires}, 64'h1 << u);
				exp_q.push_back({6'h08, u});
				rx(p, 2'(w), 1'b0);
				drain();
			end
		done("wire_map");
		wr(DS_BASE, 32'h4);
		exp_q.push_back(8'h30);
		exp_q.push_back(8'h12);
		ds_evt(0, 0);
		rx(0, 2'h0, 1'b1);
		drain();
		exp_q.push_back(8'h40);
		wr(DS_BASE + DS_STS_OFS, 32'h1);
		drain();
		rd(UP_IRQ_OFS, 32'h4);
		exp_q.push_back(8'h22);
		rx(0, 2'h0, 1'b0);
		done("own_and_rx");
		exp_q.push_back(8'h13);
		exp_q.push_back(8'h10);
		rx(1, 2'h0, 1'b1);
		rx(1, 2'h1, 1'b1);
		drain();
		exp_q.push_back(8'h20);
		exp_q.push_back(8'h23);
		@(posedge mclk);
		dl_up <= 2'b01;
		drain();
		rd(P3 + DS_IRQ_OFS, 32'h0);
		rd(UP_IRQ_OFS, 32'h0);
		dl_up <= 2'b11;
		done("link_down");
		wr(UP_CTRL_OFS, 32'h4);
		exp_q.push_back(8'h10);
		up_evt(1'b0);
		drain();
		rd(UP_IRQ_OFS, 32'h1);
		exp_q.push_back(8'h20);
		wr(UP_ERR_OFS, 32'h1);
		drain();
		wr(PM_CAP_OFS, 32'(MSI_CAP_PTR));
		rd(PM_CAP_OFS, 32'h0);
		wr(UNLOCK_OFS, 32'h1);
		wr(PM_CAP_OFS, 32'(MSI_CAP_PTR));
		rd(PM_CAP_OFS, 32'h100 | 32'(MSI_CAP_PTR));
		exp_addr = 64'h0;
		wr(UP_CTRL_OFS, 32'h9);
		exp_q.push_back(8'h50);
		up_evt(1'b1);
		drain();
		wr(UP_ERR_OFS, 32'h2);
		done("upstream_errors");
		check({56'h0, proto_errs}, 64'h0);
		tally_and_finish();
	end
endmodule : switch_port_intx_msi_aggregator_test
